// [nlcd_params.svh]
// offsets, field positions, reset values and timing figures of the no-load/current-detect block
`ifndef NLCD_PARAMS_SVH
`define NLCD_PARAMS_SVH

// register indices; byte address is four times the index
`define NLCD_IDX_PHC1 14'h287b
`define NLCD_IDX_PHC2 14'h287c
`define NLCD_IDX_PMC4 14'h287d
`define NLCD_IDX_NOLOAD 14'h287f
`define NLCD_IDX_DETCTL 14'h2886
`define NLCD_IDX_THRESH 14'h1002

// reset values
`define NLCD_RST_REG8 8'h00
`define NLCD_RST_THRESH 32'h00000000

// noload_indication fields
`define NLCD_NL_P1_CREEP 7
`define NLCD_NL_P2_CREEP 6
`define NLCD_NL_PW_HI 5
`define NLCD_NL_PW_LO 4
`define NLCD_NL_C2_HI 3
`define NLCD_NL_C2_LO 2
`define NLCD_NL_C1_HI 1
`define NLCD_NL_C1_LO 0

// current_detection_control fields
`define NLCD_DC_GATE 7
`define NLCD_DC_SEEN 6
`define NLCD_DC_CLR 5
`define NLCD_DC_EN 4
`define NLCD_DC_N_HI 3
`define NLCD_DC_N_LO 0

// phase compensation control fields and pm control 4 fields
`define NLCD_PHC_HI_HI 5
`define NLCD_PHC_HI_LO 0
`define NLCD_PM_P2_NL_EN 7
`define NLCD_PM_P1_NL_EN 6
`define NLCD_PM_ACC_EN 3

// timing: system clock and pulse widths in milliseconds
`define NLCD_CLK_HZ 100000000
`define NLCD_MS_PER_S 1000
`define NLCD_PW_SEL0_MS 80
`define NLCD_PW_SEL1_MS 40
`define NLCD_PW_SEL2_MS 20
`define NLCD_PW_SEL3_MS 10

// compensation sampling clock and step figures (megahertz times 10000, micro-degree)
`define NLCD_SMPL_MHZ_X10000 32768
`define NLCD_STEP_UDEG 5500

`endif

// [nlcd_pkg.sv]
// types shared by the no-load/current-detect block
package nlcd_pkg;
    typedef enum logic [1:0] {
        NLCD_PW_80MS,
        NLCD_PW_40MS,
        NLCD_PW_20MS,
        NLCD_PW_10MS
    } nlcd_pw_sel_t;

    typedef enum {
        NLCD_BUS_IDLE,
        NLCD_BUS_ACCESS
    } nlcd_bus_state_t;
endpackage : nlcd_pkg

// [nlcd_pulse_stretch.sv]
// stretches a one-cycle energy pulse request to a programmed width
`timescale 1ns/1ps
module nlcd_pulse_stretch (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_start,
    input wire logic [31:0] i_width,
    output logic o_pulse
);
    logic [31:0] remain;

    // requests arriving while a pulse is out are dropped, so pulses never merge
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            remain <= 32'h00000000;
            o_pulse <= 1'b0;
        end else if (!o_pulse && i_start) begin
            remain <= i_width;
            o_pulse <= 1'b1;
        end else if (o_pulse) begin
            if (remain <= 32'h00000001) begin
                o_pulse <= 1'b0;
                remain <= 32'h00000000;
            end else begin
                remain <= remain - 32'h00000001;
            end
        end
    end

    property p_pulse_starts;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !o_pulse && i_start |=> o_pulse && remain == $past(i_width);
    endproperty
    a_pulse_starts: assert property (p_pulse_starts) else $error("pulse did not start");

    property p_pulse_ends;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        o_pulse && remain == 32'h00000001 |=> !o_pulse;
    endproperty
    a_pulse_ends: assert property (p_pulse_ends) else $error("pulse too long");
endmodule : nlcd_pulse_stretch

// [nlcd_ctrl.sv]
// no-load indication, phase delay low bits and current detection register bank
// Notes on behaviour
// - bit 7 of noload_indication reads 1 while path 1 creeps and 0 while it meters.
// - bit 6 of noload_indication reads 1 while path 2 creeps and 0 while it meters.
// - bits 5:4 pick the energy pulse width: 00 80 ms, 01 40 ms, 10 20 ms, 11 10 ms.
// - channel 2 delay is the 6-bit field of phase_comp_control_two above bits 3:2.
// - channel 1 delay is the 6-bit field of phase_comp_control_one above bits 1:0.
// - at a 3.2768 MHz compensation clock one delay step is 0.0055 deg, 1.4 deg in all.
// - while the gate bit is 1 sampling and power/rms work stop but accumulation runs.
// - a caught current sets the seen flag, held until clear is written 1 or detection off.
// - detection runs only while the detection enable bit is 1.
// - a current is caught when N+1 consecutive channel 1 ac samples exceed the threshold.
// - path 1 creep state is evaluated only while its no-load enable is 1.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "nlcd_params.svh"
module nlcd_ctrl #(
    parameter int P_CYC_PER_MS = `NLCD_CLK_HZ / `NLCD_MS_PER_S
) (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [15:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_path1_creep,
    input wire logic i_path2_creep,
    input wire logic i_sample_valid,
    input wire logic [31:0] i_chan1_ac_sample,
    input wire logic i_energy_pulse_req,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    output logic o_energy_pulse_output,
    output logic [7:0] o_chan1_phase_delay,
    output logic [7:0] o_chan2_phase_delay,
    output logic o_frontend_gate,
    output logic o_accum_enable,
    output logic o_current_seen_flag
);
    // pulse widths in cycles; multiples of P_CYC_PER_MS so they scale with the parameter
    localparam logic [31:0] PW0_CYC = 32'(`NLCD_PW_SEL0_MS * P_CYC_PER_MS);
    localparam logic [31:0] PW1_CYC = 32'(`NLCD_PW_SEL1_MS * P_CYC_PER_MS);
    localparam logic [31:0] PW2_CYC = 32'(`NLCD_PW_SEL2_MS * P_CYC_PER_MS);
    localparam logic [31:0] PW3_CYC = 32'(`NLCD_PW_SEL3_MS * P_CYC_PER_MS);

    nlcd_pkg::nlcd_bus_state_t bus_state;
    logic [7:0] phase_comp_control_one;
    logic [7:0] phase_comp_control_two;
    logic [7:0] pm_control_four;
    logic [31:0] detection_threshold;
    logic path1_creep_flag;
    logic path2_creep_flag;
    nlcd_pkg::nlcd_pw_sel_t energy_pulse_width_sel;
    logic [1:0] chan2_phase_delay_low;
    logic [1:0] chan1_phase_delay_low;
    logic frontend_gate;
    logic current_seen_flag;
    logic seen_flag_clear;
    logic detection_enable;
    logic [3:0] consecutive_sample_count;
    logic [4:0] run_cnt;
    logic [31:0] pulse_width_cyc;
    logic [13:0] idx;
    logic wr_en;
    logic hit;
    logic caught;
    logic [31:0] next_rdata;
    logic next_err;

    assign idx = i_paddr[15:2];
    assign wr_en = (bus_state == nlcd_pkg::NLCD_BUS_ACCESS) && i_psel && i_penable && i_pwrite;
    // a sample counts only while detection runs and the front end is not gated
    assign hit = i_sample_valid && detection_enable && !frontend_gate
        && ($signed(i_chan1_ac_sample) > $signed(detection_threshold));
    // at-or-above keeps a run that outgrew a newly lowered N able to catch on its next hit
    assign caught = hit && (run_cnt >= {1'b0, consecutive_sample_count});

    // read mux and decode; unmapped index answers with slave error
    always_comb begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        case (idx)
            `NLCD_IDX_PHC1: next_rdata = {24'h000000, phase_comp_control_one};
            `NLCD_IDX_PHC2: next_rdata = {24'h000000, phase_comp_control_two};
            `NLCD_IDX_PMC4: next_rdata = {24'h000000, pm_control_four};
            `NLCD_IDX_THRESH: next_rdata = detection_threshold;
            `NLCD_IDX_NOLOAD: next_rdata = {24'h000000, path1_creep_flag, path2_creep_flag,
                energy_pulse_width_sel, chan2_phase_delay_low, chan1_phase_delay_low};
            `NLCD_IDX_DETCTL: next_rdata = {24'h000000, frontend_gate, current_seen_flag,
                seen_flag_clear, detection_enable, consecutive_sample_count};
            default: next_err = 1'b1;
        endcase
    end

    // apb slave: data captured in setup, one access cycle with pready high
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            bus_state <= nlcd_pkg::NLCD_BUS_IDLE;
            o_pready <= 1'b0;
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
        end else begin
            case (bus_state)
                nlcd_pkg::NLCD_BUS_IDLE: begin
                    if (i_psel && !i_penable) begin
                        bus_state <= nlcd_pkg::NLCD_BUS_ACCESS;
                        o_pready <= 1'b1;
                        o_prdata <= i_pwrite ? 32'h00000000 : next_rdata;
                        o_pslverr <= next_err;
                    end
                end
                nlcd_pkg::NLCD_BUS_ACCESS: begin
                    bus_state <= nlcd_pkg::NLCD_BUS_IDLE;
                    o_pready <= 1'b0;
                    o_pslverr <= 1'b0;
                end
                default: begin
                    bus_state <= nlcd_pkg::NLCD_BUS_IDLE;
                    o_pready <= 1'b0;
                end
            endcase
        end
    end

    // plain read/write control registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            phase_comp_control_one <= `NLCD_RST_REG8;
            phase_comp_control_two <= `NLCD_RST_REG8;
            pm_control_four <= `NLCD_RST_REG8;
            detection_threshold <= `NLCD_RST_THRESH;
        end else if (wr_en && !o_pslverr) begin
            case (idx)
                `NLCD_IDX_PHC1: phase_comp_control_one <= i_pwdata[7:0];
                `NLCD_IDX_PHC2: phase_comp_control_two <= i_pwdata[7:0];
                `NLCD_IDX_PMC4: pm_control_four <= i_pwdata[7:0];
                `NLCD_IDX_THRESH: detection_threshold <= i_pwdata;
                default: begin
                end
            endcase
        end
    end

    // writable fields of the indication and detection control registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            energy_pulse_width_sel <= nlcd_pkg::NLCD_PW_80MS;
            chan2_phase_delay_low <= 2'h0;
            chan1_phase_delay_low <= 2'h0;
            frontend_gate <= 1'b0;
            seen_flag_clear <= 1'b0;
            detection_enable <= 1'b0;
            consecutive_sample_count <= 4'h0;
        end else if (wr_en && idx == `NLCD_IDX_NOLOAD) begin
            energy_pulse_width_sel <= nlcd_pkg::nlcd_pw_sel_t'(i_pwdata[`NLCD_NL_PW_HI:`NLCD_NL_PW_LO]);
            chan2_phase_delay_low <= i_pwdata[`NLCD_NL_C2_HI:`NLCD_NL_C2_LO];
            chan1_phase_delay_low <= i_pwdata[`NLCD_NL_C1_HI:`NLCD_NL_C1_LO];
        end else if (wr_en && idx == `NLCD_IDX_DETCTL) begin
            frontend_gate <= i_pwdata[`NLCD_DC_GATE];
            seen_flag_clear <= i_pwdata[`NLCD_DC_CLR];
            detection_enable <= i_pwdata[`NLCD_DC_EN];
            consecutive_sample_count <= i_pwdata[`NLCD_DC_N_HI:`NLCD_DC_N_LO];
        end
    end

    // creep states; a disabled path always reads as metering
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            path1_creep_flag <= 1'b0;
            path2_creep_flag <= 1'b0;
        end else begin
            path1_creep_flag <= pm_control_four[`NLCD_PM_P1_NL_EN] && i_path1_creep;
            path2_creep_flag <= pm_control_four[`NLCD_PM_P2_NL_EN] && i_path2_creep;
        end
    end

    // consecutive-sample run counter, saturating at N+1 of the current N
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            run_cnt <= 5'h00;
        end else if (!detection_enable) begin
            run_cnt <= 5'h00;
        end else if (i_sample_valid && !frontend_gate) begin
            if (!hit) begin
                run_cnt <= 5'h00;
            end else if (run_cnt < {1'b0, consecutive_sample_count}) begin
                run_cnt <= run_cnt + 5'h01;
            end else begin
                run_cnt <= {1'b0, consecutive_sample_count} + 5'h01;
            end
        end
    end

    // sticky seen flag; a catch in the clearing cycle wins over the clear
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            current_seen_flag <= 1'b0;
        end else if (caught) begin
            current_seen_flag <= 1'b1;
        end else if (seen_flag_clear || !detection_enable) begin
            current_seen_flag <= 1'b0;
        end
    end

    // pulse width lookup, registered so the stretcher sees a stable width
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            pulse_width_cyc <= PW0_CYC;
        end else begin
            case (energy_pulse_width_sel)
                nlcd_pkg::NLCD_PW_80MS: pulse_width_cyc <= PW0_CYC;
                nlcd_pkg::NLCD_PW_40MS: pulse_width_cyc <= PW1_CYC;
                nlcd_pkg::NLCD_PW_20MS: pulse_width_cyc <= PW2_CYC;
                nlcd_pkg::NLCD_PW_10MS: pulse_width_cyc <= PW3_CYC;
                default: pulse_width_cyc <= PW0_CYC;
            endcase
        end
    end

    // outputs; delay counts whole compensation-sample periods, so step size follows that clock
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_chan1_phase_delay <= 8'h00;
            o_chan2_phase_delay <= 8'h00;
            o_frontend_gate <= 1'b0;
            o_accum_enable <= 1'b0;
            o_current_seen_flag <= 1'b0;
        end else begin
            o_chan1_phase_delay <= {phase_comp_control_one[`NLCD_PHC_HI_HI:`NLCD_PHC_HI_LO],
                chan1_phase_delay_low};
            o_chan2_phase_delay <= {phase_comp_control_two[`NLCD_PHC_HI_HI:`NLCD_PHC_HI_LO],
                chan2_phase_delay_low};
            o_frontend_gate <= frontend_gate;
            o_accum_enable <= pm_control_four[`NLCD_PM_ACC_EN];
            o_current_seen_flag <= current_seen_flag;
        end
    end

    // the gate does not touch the accumulator path, so pulses keep flowing
    nlcd_pulse_stretch u_pulse (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_start(i_energy_pulse_req),
        .i_width(pulse_width_cyc),
        .o_pulse(o_energy_pulse_output)
    );

    property p_path1_creep;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        1'b1 |=> path1_creep_flag == ($past(pm_control_four[6]) && $past(i_path1_creep));
    endproperty
    a_path1_creep: assert property (p_path1_creep) else $error("path1 creep wrong");

    property p_path2_creep;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        1'b1 |=> path2_creep_flag == ($past(pm_control_four[7]) && $past(i_path2_creep));
    endproperty
    a_path2_creep: assert property (p_path2_creep) else $error("path2 creep lost");

    property p_chan1_delay;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        wr_en && idx == `NLCD_IDX_NOLOAD |=> ##1 o_chan1_phase_delay[1:0] == $past(i_pwdata[1:0], 2);
    endproperty
    a_chan1_delay: assert property (p_chan1_delay) else $error("chan1 delay low wrong");

    property p_chan2_delay;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        wr_en && idx == `NLCD_IDX_PHC2 |=> ##1 o_chan2_phase_delay[7:2] == $past(i_pwdata[5:0], 2);
    endproperty
    a_chan2_delay: assert property (p_chan2_delay) else $error("chan2 delay high wrong");

    property p_gate_out;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        frontend_gate && detection_enable && i_sample_valid |=> $stable(run_cnt) ##1 o_frontend_gate;
    endproperty
    a_gate_out: assert property (p_gate_out) else $error("gate did not halt front end");

    property p_caught_sets;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        caught |=> current_seen_flag ##1 o_current_seen_flag;
    endproperty
    a_caught_sets: assert property (p_caught_sets) else $error("seen flag not set");

    property p_clear;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        seen_flag_clear && !caught |=> !current_seen_flag;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not clear");

    property p_disabled;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !detection_enable |=> run_cnt == 5'h00 && !current_seen_flag;
    endproperty
    a_disabled: assert property (p_disabled) else $error("detection ran while off");

    property p_rise_count;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        $rose(current_seen_flag) |-> run_cnt == {1'b0, $past(consecutive_sample_count)} + 5'h01;
    endproperty
    a_rise_count: assert property (p_rise_count) else $error("caught at wrong count");

    property p_miss_restarts;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        i_sample_valid && detection_enable && !frontend_gate && !hit |=> run_cnt == 5'h00;
    endproperty
    a_miss_restarts: assert property (p_miss_restarts) else $error("run not restarted");

    property p_width_sel;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        energy_pulse_width_sel == nlcd_pkg::NLCD_PW_10MS |=> pulse_width_cyc == PW3_CYC;
    endproperty
    a_width_sel: assert property (p_width_sel) else $error("pulse width select wrong");
endmodule : nlcd_ctrl

// [nlcd_ctrl_tb.sv]
// self-checking bench of the no-load/current-detect register bank
`timescale 1ns/1ps
`include "nlcd_params.svh"
module nlcd_ctrl_tb;
    typedef struct packed {
        logic wr;
        logic [13:0] idx;
        logic [31:0] wd;
        logic [31:0] ex;
        logic er;
    } nlcd_row_t;
    // short millisecond keeps the longest pulse at 800 cycles
    localparam int P_MS = 10;
    logic i_clk_sys, i_resetn, i_psel, i_penable, i_pwrite;
    logic [15:0] i_paddr;
    logic [31:0] i_pwdata, i_chan1_ac_sample, o_prdata;
    logic i_path1_creep, i_path2_creep, i_sample_valid, i_energy_pulse_req;
    logic o_pready, o_pslverr, o_energy_pulse_output, o_frontend_gate;
    logic o_accum_enable, o_current_seen_flag;
    logic [7:0] o_chan1_phase_delay, o_chan2_phase_delay;
    int mismatches = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic er;
    nlcd_row_t rows [12];
    logic [13:0] regs [6];
    int pw_ms [4];

    nlcd_ctrl #(.P_CYC_PER_MS(P_MS)) dut_u (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .i_path1_creep(i_path1_creep), .i_path2_creep(i_path2_creep),
        .i_sample_valid(i_sample_valid), .i_chan1_ac_sample(i_chan1_ac_sample),
        .i_energy_pulse_req(i_energy_pulse_req), .o_pready(o_pready),
        .o_prdata(o_prdata), .o_pslverr(o_pslverr),
        .o_energy_pulse_output(o_energy_pulse_output),
        .o_chan1_phase_delay(o_chan1_phase_delay), .o_chan2_phase_delay(o_chan2_phase_delay),
        .o_frontend_gate(o_frontend_gate), .o_accum_enable(o_accum_enable),
        .o_current_seen_flag(o_current_seen_flag)
    );

    // 100 MHz system clock
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    task automatic wrap_up();
        $display("counts: mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] ex);
        comparisons++;
        if (got !== ex) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask : chk

    // one apb transfer; pready, read data and error are all taken at the rising edge
    task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
        int n;
        @(posedge i_clk_sys);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= {idx, 2'b00};
        i_pwdata <= wd;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (o_pready !== 1'b1) begin
            mismatches++;
            wrap_up();
        end
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    // one channel 1 sample, valid for a single cycle
    task automatic smp(input logic [31:0] v);
        @(posedge i_clk_sys);
        i_sample_valid <= 1'b1;
        i_chan1_ac_sample <= v;
        @(posedge i_clk_sys);
        i_sample_valid <= 1'b0;
    endtask : smp

    // flag output trails the register bit by one edge, so allow three
    task automatic seen(input logic ex);
        repeat (3) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chk({31'h0, o_current_seen_flag}, {31'h0, ex});
    endtask : seen

    task automatic pulse(input int ex);
        int w;
        @(posedge i_clk_sys);
        i_energy_pulse_req <= 1'b1;
        @(posedge i_clk_sys);
        i_energy_pulse_req <= 1'b0;
        w = 0;
        @(negedge i_clk_sys);
        while (o_energy_pulse_output === 1'b1 && w < 2000) begin
            @(negedge i_clk_sys);
            w++;
        end
        if (w >= 2000) begin
            mismatches++;
            wrap_up();
        end
        chk(w, ex);
    endtask : pulse

    // main sequence: reset, table of register accesses, then hand-written cases
    initial begin
        {i_resetn, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
        {i_path1_creep, i_path2_creep, i_sample_valid, i_chan1_ac_sample} = '0;
        i_energy_pulse_req = 1'b0;
        pw_ms = '{`NLCD_PW_SEL0_MS, `NLCD_PW_SEL1_MS, `NLCD_PW_SEL2_MS, `NLCD_PW_SEL3_MS};
        regs = '{`NLCD_IDX_PHC1, `NLCD_IDX_PHC2, `NLCD_IDX_PMC4, `NLCD_IDX_NOLOAD,
                 `NLCD_IDX_DETCTL, `NLCD_IDX_THRESH};
        rows = '{
            '{1'b1, `NLCD_IDX_PHC1, 32'hffffffa5, 32'h0, 1'b0},
            '{1'b0, `NLCD_IDX_PHC1, 32'h0, 32'h000000a5, 1'b0},
            '{1'b1, `NLCD_IDX_PHC2, 32'h0000003c, 32'h0, 1'b0},
            '{1'b0, `NLCD_IDX_PHC2, 32'h0, 32'h0000003c, 1'b0},
            '{1'b1, `NLCD_IDX_NOLOAD, 32'h000000ff, 32'h0, 1'b0},
            '{1'b0, `NLCD_IDX_NOLOAD, 32'h0, 32'h0000003f, 1'b0},
            '{1'b1, `NLCD_IDX_DETCTL, 32'h0000004f, 32'h0, 1'b0},
            '{1'b0, `NLCD_IDX_DETCTL, 32'h0, 32'h0000000f, 1'b0},
            '{1'b1, `NLCD_IDX_THRESH, 32'h80000001, 32'h0, 1'b0},
            '{1'b0, `NLCD_IDX_THRESH, 32'h0, 32'h80000001, 1'b0},
            '{1'b1, 14'h287e, 32'h000000ff, 32'h0, 1'b1},
            '{1'b0, 14'h287e, 32'h0, 32'h0, 1'b1}
        };
        repeat (12) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        @(negedge i_clk_sys);
        chk({o_energy_pulse_output, o_frontend_gate, o_accum_enable, o_current_seen_flag,
             o_chan1_phase_delay, o_chan2_phase_delay}, 32'h0);
        foreach (regs[i]) begin
            apb(1'b0, regs[i], 32'h0);
            chk(rd, 32'h0);
        end
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].idx, rows[i].wd);
            if (!rows[i].wr) chk(rd, rows[i].ex);
            chk({31'h0, er}, {31'h0, rows[i].er});
        end
        chk(o_chan1_phase_delay, 8'h97);
        chk(o_chan2_phase_delay, 8'hf3);
        // creep bits follow the paths only while no-load detection is enabled
        apb(1'b1, `NLCD_IDX_PMC4, 32'h000000c8);
        i_path1_creep <= 1'b1;
        apb(1'b0, `NLCD_IDX_NOLOAD, 32'h0);
        chk(rd, 32'h000000bf);
        i_path1_creep <= 1'b0;
        i_path2_creep <= 1'b1;
        apb(1'b0, `NLCD_IDX_NOLOAD, 32'h0);
        chk(rd, 32'h0000007f);
        apb(1'b1, `NLCD_IDX_PMC4, 32'h00000008);
        i_path1_creep <= 1'b1;
        apb(1'b0, `NLCD_IDX_NOLOAD, 32'h0);
        chk(rd, 32'h0000003f);
        {i_path1_creep, i_path2_creep} <= 2'b00;
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, `NLCD_IDX_NOLOAD, {26'h0, s[1:0], 4'hf});
            pulse(pw_ms[s] * P_MS);
        end
        // detection: runs broken by an at-threshold and a negative sample never catch
        apb(1'b1, `NLCD_IDX_THRESH, 32'd100);
        apb(1'b1, `NLCD_IDX_DETCTL, 32'h00000012);
        smp(32'd150);
        smp(32'd150);
        smp(32'd100);
        smp(32'd150);
        smp(32'd150);
        smp(32'hffffff9c);
        seen(1'b0);
        repeat (3) smp(32'd150);
        seen(1'b1);
        apb(1'b0, `NLCD_IDX_DETCTL, 32'h0);
        chk(rd, 32'h00000052);
        apb(1'b1, `NLCD_IDX_DETCTL, 32'h00000032);
        apb(1'b1, `NLCD_IDX_DETCTL, 32'h00000012);
        seen(1'b0);
        // lowering N under a run that is already long catches on the next hit
        apb(1'b1, `NLCD_IDX_DETCTL, 32'h00000010);
        smp(32'd150);
        seen(1'b1);
        apb(1'b1, `NLCD_IDX_DETCTL, 32'h00000000);
        seen(1'b0);
        repeat (3) smp(32'd150);
        apb(1'b1, `NLCD_IDX_DETCTL, 32'h00000012);
        smp(32'd150);
        smp(32'd150);
        seen(1'b0);
        smp(32'd50);
        // threshold was programmed long before the gate goes up
        apb(1'b1, `NLCD_IDX_DETCTL, 32'h00000092);
        repeat (3) smp(32'd150);
        seen(1'b0);
        chk({o_frontend_gate, o_accum_enable}, 2'b11);
        // mid-run reset returns outputs and registers to their reset values
        i_resetn <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        @(negedge i_clk_sys);
        chk({o_frontend_gate, o_accum_enable, o_current_seen_flag, o_chan1_phase_delay}, 32'h0);
        apb(1'b0, `NLCD_IDX_DETCTL, 32'h0);
        chk(rd, 32'h0);
        wrap_up();
    end
endmodule : nlcd_ctrl_tb
